//--- verilog/acc_defs.vh
// Register offsets, field positions, reset values and timing counts for the converter control
`ifndef ACC_DEFS_VH
`define ACC_DEFS_VH

`define ACC_CTL0_ADDR 8'h00
`define ACC_CTL1_ADDR 8'h04
`define ACC_RESH_ADDR 8'h08
`define ACC_RESL_ADDR 8'h0c

`define ACC_CTL0_SEL_LSB 0
`define ACC_CTL0_SEL_MSB 3
`define ACC_CTL0_REFSL_BIT 4
`define ACC_CTL0_REFPIN_BIT 5
`define ACC_CTL0_REPEAT_BIT 6
`define ACC_CTL0_GO_BIT 7
`define ACC_CTL1_REFSH_BIT 0
`define ACC_CTL1_BUSY_BIT 7

`define ACC_CTL0_RESET 8'h00
`define ACC_CTL1_RESET 8'h00

`define ACC_CLK_MHZ 100
`define ACC_FIRST_CYC 13'h1409
`define ACC_PWRUP_CYC 13'h0028
`define ACC_NEXT_CYC 13'h0100
`define ACC_CNT_W 13

`endif

//--- verilog/acc_sampler.v
// Result register pair that captures each completed conversion value
`default_nettype none

module acc_sampler (
    input wire CLK,
    input wire RST,
    input wire load,
    input wire [12:0] value,
    output reg [7:0] high_r,
    output reg [7:0] low_r
);

    always @(posedge CLK) begin
        if (RST) begin
            high_r <= 8'h00;
            low_r <= 8'h00;
        end else if (load) begin
            high_r <= value[12:5];
            low_r <= {value[4:0], 3'h0};
        end
    end

endmodule // acc_sampler

`default_nettype wire

//--- verilog/acc_ctrl.v
// Continuous conversion control block with classic Wishbone register access
// Overview of operation
// - One write to control register 0 sets input, mode, low reference bit, reference pin and start together
// - Four-bit input select field picks the converted analog input
// - Repeat bit at one selects repeated conversions instead of one
// - Writing one to the go bit starts the conversion sequence
// - First result after 5129 cycles, plus 40 when powering up
// - Go bit clears at first completion and stays zero while repeating
// - Later results arrive every 256 cycles while repeat mode holds
// - 13-bit result: upper eight in high byte, low five in bits 7:3
// - Every completed conversion raises a conversion complete request
// - Clearing the repeat bit stops continuous conversion
// - Disabled converter raises no new conversion requests
// - Disabling leaves a pending conversion request untouched
// - Reference code is split over low select bit and high select bit
`default_nettype none
`include "acc_defs.vh"

module acc_ctrl (
    input wire CLK,
    input wire RST,
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_WE_I,
    input wire [7:0] WB_ADR_I,
    input wire [31:0] WB_DAT_I,
    input wire [3:0] WB_SEL_I,
    output reg [31:0] WB_DAT_O,
    output reg WB_ACK_O,
    output wire WB_ERR_O,
    input wire IRQ_ACK,
    output reg IRQ_REQ,
    input wire [12:0] AFE_RESULT,
    output wire [3:0] AFE_INPUT_SEL,
    output wire [1:0] AFE_REF_SEL,
    output wire AFE_REF_TO_PIN,
    output wire AFE_POWER
);

    localparam ST_IDLE = 2'd0;
    localparam ST_FIRST = 2'd1;
    localparam ST_REPEAT = 2'd2;

    localparam [12:0] FIRST_CNT = `ACC_FIRST_CYC;
    localparam [12:0] PWRUP_CNT = `ACC_PWRUP_CYC;
    localparam [12:0] NEXT_CNT = `ACC_NEXT_CYC;

    reg [7:0] ctl0_r;
    reg ref_high_r;
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [12:0] cnt_r;
    reg [12:0] cnt_nxt;
    reg powered_r;
    reg [12:0] afe_s1_r;
    reg [12:0] afe_s2_r;
    wire [7:0] res_high;
    wire [7:0] res_low;
    wire wr_ctl0;
    wire wr_ctl1;
    wire go_write;
    wire done;
    wire repeat_mode;
    wire addr_ok;

    assign addr_ok = (WB_ADR_I == `ACC_CTL0_ADDR) || (WB_ADR_I == `ACC_CTL1_ADDR) ||
                     (WB_ADR_I == `ACC_RESH_ADDR) || (WB_ADR_I == `ACC_RESL_ADDR);
    assign WB_ERR_O = WB_CYC_I && WB_STB_I && !addr_ok && !WB_ACK_O;

    // Write strobes on the acknowledged edge
    assign wr_ctl0 = WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O && WB_SEL_I[0] &&
                     (WB_ADR_I == `ACC_CTL0_ADDR);
    assign wr_ctl1 = WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O && WB_SEL_I[0] &&
                     (WB_ADR_I == `ACC_CTL1_ADDR);
    assign go_write = wr_ctl0 && WB_DAT_I[`ACC_CTL0_GO_BIT];

    assign repeat_mode = ctl0_r[`ACC_CTL0_REPEAT_BIT];
    assign done = (state_r != ST_IDLE) && (cnt_r == 13'h0001);

    assign AFE_INPUT_SEL = ctl0_r[`ACC_CTL0_SEL_MSB:`ACC_CTL0_SEL_LSB];
    assign AFE_REF_SEL = {ref_high_r, ctl0_r[`ACC_CTL0_REFSL_BIT]};
    assign AFE_REF_TO_PIN = ctl0_r[`ACC_CTL0_REFPIN_BIT];
    assign AFE_POWER = powered_r;

    // Wishbone acknowledge and read data
    always @(posedge CLK) begin
        if (RST) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h00000000;
        end else begin
            WB_ACK_O <= WB_CYC_I && WB_STB_I && addr_ok && !WB_ACK_O;
            case (WB_ADR_I)
                `ACC_CTL0_ADDR: WB_DAT_O <= {24'h000000, ctl0_r};
                `ACC_CTL1_ADDR: WB_DAT_O <= {24'h000000, (state_r != ST_IDLE), 6'h00,
                                             ref_high_r};
                `ACC_RESH_ADDR: WB_DAT_O <= {24'h000000, res_high};
                `ACC_RESL_ADDR: WB_DAT_O <= {24'h000000, res_low};
                default: WB_DAT_O <= 32'h00000000;
            endcase
        end
    end

    // Control registers; go bit cleared by hardware at first completion
    always @(posedge CLK) begin
        if (RST) begin
            ctl0_r <= `ACC_CTL0_RESET;
            ref_high_r <= 1'b0;
        end else begin
            if (wr_ctl0) begin
                ctl0_r <= WB_DAT_I[7:0];
            end
            if (done && state_r == ST_FIRST && !go_write) begin
                ctl0_r[`ACC_CTL0_GO_BIT] <= 1'b0;
            end
            if (wr_ctl1) begin
                ref_high_r <= WB_DAT_I[`ACC_CTL1_REFSH_BIT];
            end
        end
    end

    // Conversion sequencer
    always @* begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            ST_IDLE: begin
                if (go_write) begin
                    state_nxt = ST_FIRST;
                    cnt_nxt = powered_r ? FIRST_CNT : FIRST_CNT + PWRUP_CNT;
                end
            end
            ST_FIRST: begin
                if (done) begin
                    if (repeat_mode) begin
                        state_nxt = ST_REPEAT;
                        cnt_nxt = NEXT_CNT;
                    end else begin
                        state_nxt = ST_IDLE;
                        cnt_nxt = 13'h0000;
                    end
                end else begin
                    cnt_nxt = cnt_r - 13'h0001;
                end
            end
            ST_REPEAT: begin
                if (!repeat_mode) begin
                    state_nxt = ST_IDLE;
                    cnt_nxt = 13'h0000;
                end else if (done) begin
                    cnt_nxt = NEXT_CNT;
                end else begin
                    cnt_nxt = cnt_r - 13'h0001;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
                cnt_nxt = 13'h0000;
            end
        endcase
    end

    always @(posedge CLK) begin
        if (RST) begin
            state_r <= ST_IDLE;
            cnt_r <= 13'h0000;
            powered_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            powered_r <= (state_nxt != ST_IDLE);
        end
    end

    // Analog result passes two flops before use
    always @(posedge CLK) begin
        if (RST) begin
            afe_s1_r <= 13'h0000;
            afe_s2_r <= 13'h0000;
        end else begin
            afe_s1_r <= AFE_RESULT;
            afe_s2_r <= afe_s1_r;
        end
    end

    // Interrupt request: set on completion wins over acknowledge; disabling never clears it
    always @(posedge CLK) begin
        if (RST) begin
            IRQ_REQ <= 1'b0;
        end else if (done && (state_r == ST_FIRST || repeat_mode)) begin
            IRQ_REQ <= 1'b1;
        end else if (IRQ_ACK) begin
            IRQ_REQ <= 1'b0;
        end
    end

    acc_sampler u_sampler (
        .CLK(CLK),
        .RST(RST),
        .load(done && (state_r == ST_FIRST || repeat_mode)),
        .value(afe_s2_r),
        .high_r(res_high),
        .low_r(res_low)
    );

endmodule // acc_ctrl

`default_nettype wire

//--- tb/acc_irq_model.sv
// Interrupt controller model that acknowledges conversion requests
`default_nettype none
module acc_irq_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic irq_req,
    output logic irq_ack
);
    int wt;
    always @(posedge clk) begin
        if (rst || !irq_req) begin
            irq_ack <= 1'b0;
            wt <= 0;
        end else if (wt >= (slow ? 300 : 3)) begin
            irq_ack <= 1'b1;
        end else begin
            wt <= wt + 1;
        end
    end
endmodule // acc_irq_model
`default_nettype wire

//--- tb/acc_ctrl_props.sv
// Concurrent checks on the converter control ports
`default_nettype none
module acc_ctrl_props (
    input wire logic CLK,
    input wire logic RST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic WB_ACK_O,
    input wire logic IRQ_ACK,
    input wire logic IRQ_REQ,
    input wire logic [3:0] AFE_INPUT_SEL,
    input wire logic [1:0] AFE_REF_SEL,
    input wire logic AFE_POWER
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    wire logic wr0 = WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O && WB_ADR_I == 8'h00;
    wire logic [3:0] ds = WB_DAT_I[3:0];
    wire logic d4 = WB_DAT_I[4];
    property p_ack_one; WB_ACK_O |=> !WB_ACK_O; endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack too long");
    property p_sel; wr0 |=> AFE_INPUT_SEL == $past(ds); endproperty
    a_sel: assert property (p_sel) else $error("input select");
    property p_ref; wr0 |=> AFE_REF_SEL[0] == $past(d4); endproperty
    a_ref: assert property (p_ref) else $error("reference select");
    property p_go; wr0 && WB_DAT_I[7] && !AFE_POWER |-> ##[1:2] AFE_POWER; endproperty
    a_go: assert property (p_go) else $error("no start");
    property p_stop; wr0 && !WB_DAT_I[7:6] |-> ##[1:300] !AFE_POWER; endproperty
    a_stop: assert property (p_stop) else $error("no stop");
    property p_idle; !AFE_POWER [*2] |-> !$rose(IRQ_REQ); endproperty
    a_idle: assert property (p_idle) else $error("request while idle");
    property p_hold; IRQ_REQ && !IRQ_ACK |=> IRQ_REQ; endproperty
    a_hold: assert property (p_hold) else $error("request lost");
    property p_period; $rose(IRQ_REQ) && AFE_POWER |-> ##256 ($rose(IRQ_REQ) || !AFE_POWER);
    endproperty
    a_period: assert property (p_period) else $error("bad period");
endmodule // acc_ctrl_props
`default_nettype wire

//--- tb/acc_ctrl_tb_top.sv
// Self-checking bench for the converter control block
`default_nettype none
`include "acc_defs.vh"
module acc_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, cyc, stb, we, slow, irq_ack, ack, err, irq, pwr, pin;
    logic [7:0] adr;
    logic [31:0] dat, rd, q, d, e;
    logic [12:0] res;
    logic [3:0] isel;
    logic [1:0] rsel;
    int n_fail, checks_done, seed, n;
    acc_ctrl acc_ctrl_inst (.CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_DAT_I(dat), .WB_SEL_I(4'hf), .WB_DAT_O(rd), .WB_ACK_O(ack),
        .WB_ERR_O(err), .IRQ_ACK(irq_ack), .IRQ_REQ(irq), .AFE_RESULT(res),
        .AFE_INPUT_SEL(isel), .AFE_REF_SEL(rsel), .AFE_REF_TO_PIN(pin), .AFE_POWER(pwr));
    acc_irq_model acc_irq_model_inst (.clk(clk), .rst(rst), .slow(slow), .irq_req(irq),
        .irq_ack(irq_ack));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        checks_done++;
        if (x !== g) begin
            n_fail++;
            $display("BAD %s exp %h got %h", nm, x, g);
        end
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [31:0] v);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= v;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1 && err !== 1'b1);
        q = ack ? rd : 32'hffffffff;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task wait_irq(input int lim);
        n = 0;
        while (irq !== 1'b1 && n < lim) begin
            @(posedge clk);
            n++;
        end
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        seed = 17224;
        {n_fail, checks_done, n} = 0;
        rst = 1'b1;
        {cyc, stb, we, slow, adr, dat, res} = '0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        wb(0, `ACC_CTL0_ADDR, 0);
        chk("ctl0", `ACC_CTL0_RESET, q);
        wb(0, 8'h10, 0);
        chk("unmapped", 32'hffffffff, q);
        $display("reset and map test done");
        res <= $random(seed);
        d = {24'h0, 3'b110, 5'($random(seed))};
        wb(1, `ACC_CTL1_ADDR, 1);
        wb(1, `ACC_CTL0_ADDR, d);
        chk("isel", d[3:0], isel);
        chk("rsel", {1'b1, d[4]}, rsel);
        chk("pin", d[5], pin);
        wait_irq(6000);
        e = `ACC_FIRST_CYC + `ACC_PWRUP_CYC - 2;
        chk("first", 1, n >= e - 1 && n <= e + 1);
        repeat (3) begin
            e = res;
            res <= $random(seed);
            wb(0, `ACC_RESH_ADDR, 0);
            chk("high", e[12:5], q);
            wb(0, `ACC_RESL_ADDR, 0);
            chk("low", {e[4:0], 3'b000}, q);
            wb(0, `ACC_CTL0_ADDR, 0);
            chk("ctl0", d & 32'h7f, q);
            wait_irq(300);
            chk("irq", 1, irq);
        end
        wb(1, `ACC_CTL0_ADDR, d & 32'h3f);
        repeat (300) @(posedge clk);
        wait_irq(600);
        chk("stopped", 0, irq);
        $display("continuous test done");
        slow <= 1'b1;
        wb(1, `ACC_CTL0_ADDR, 32'h80);
        wait_irq(6000);
        chk("single", 1, irq);
        repeat (150) @(posedge clk);
        chk("pending", 1, irq);
        repeat (800) @(posedge clk);
        chk("one only", 0, irq);
        $display("single test done");
        give_verdict();
    end
    initial begin
        #400000;
        n_fail++;
        give_verdict();
    end
endmodule // acc_ctrl_tb_top
bind acc_ctrl acc_ctrl_props acc_ctrl_props_inst (.CLK(CLK), .RST(RST), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I),
    .WB_ACK_O(WB_ACK_O), .IRQ_ACK(IRQ_ACK), .IRQ_REQ(IRQ_REQ), .AFE_INPUT_SEL(AFE_INPUT_SEL),
    .AFE_REF_SEL(AFE_REF_SEL), .AFE_POWER(AFE_POWER));
`default_nettype wire
